// *** hw/test_pin_sync.v ***
`timescale 1ns/1ps
// Two-stage synchroniser for one pin; only the second stage is read.
module test_pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_sys, // System clock.
  input wire srst, // Synchronous reset.
  input wire pin, // Asynchronous pin.
  output reg sync_q // Synchronised level.
);
  reg meta_q;

  // First stage feeds only the second stage.
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end
endmodule // test_pin_sync

// *** hw/trace_scan_map.vh ***
`ifndef TRACE_SCAN_MAP_VH
`define TRACE_SCAN_MAP_VH
// Scan chain selection and layout.
`define CHAIN_TRACE 4'h6
`define CHAIN_W 4
`define DATA_W 32
`define ADDR_W 7
`define SCAN_W 40
`define FLD_DATA_LSB 0
`define FLD_ADDR_LSB 32
`define FLD_DIR_BIT 39
`define IR_W 4
// Synchroniser reset levels, {trst_n, tdi, tms, tck}: idle pins high, test reset asserted.
`define SYNC_RST_VAL 4'h7
// Instruction codes.
`define IR_SCAN_N 4'h2
`define IR_INTEST 4'hc
`define IR_BYPASS 4'hf
`define IR_RESET 4'he
// TAP state codes.
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PAU_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UPD_IR 4'hf
`endif

// *** hw/trace_scan_port.v ***
`timescale 1ns/1ps
`include "trace_scan_map.vh"
module trace_scan_port #(
  parameter NREG = 128
) (
  input wire clk_sys, // System clock, 10 MHz.
  input wire srst, // Synchronous reset, active high.
  input wire tck, // Test clock pin.
  input wire tms, // Test mode select pin.
  input wire tdi, // Test data input pin.
  input wire trst_n, // Test reset pin, active low.
  output reg tdo_q, // Test data output.
  output reg tdo_oe_q, // Output enable of tdo, high while driven.
  output reg reg_wr_q, // One-cycle write strobe to trace registers.
  output reg reg_rd_q, // One-cycle read strobe to trace registers.
  output reg [`ADDR_W-1:0] reg_addr_q, // Register address.
  output reg [`DATA_W-1:0] reg_wdata_q, // Write data.
  input wire [`DATA_W-1:0] reg_rdata // Read data, valid with reg_rd_q next cycle.
);
  wire tck_s, tms_s, tdi_s, trst_s;
  reg tck_prev_q;
  reg [3:0] st_q;
  reg [`IR_W-1:0] ir_q, ir_sh_q;
  reg [`CHAIN_W-1:0] chain_q, chain_sh_q;
  reg [`SCAN_W-1:0] scan_q;
  reg byp_q;
  reg [`DATA_W-1:0] rd_hold_q;
  reg rd_pend_q;
  reg tdo_d;

  // Pin synchronisers, one per pin; a generate loop builds the four alike except for their reset levels.
  // Reset levels match the idle pins: tck, tms and tdi rest high, so no false tck edge follows
  // reset, while trst_n starts asserted so the controller stays in reset until the pin is seen high.
  localparam [3:0] PIN_RST = `SYNC_RST_VAL;
  wire [3:0] pin_raw = {trst_n, tdi, tms, tck};
  wire [3:0] pin_s;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      test_pin_sync #(.RESET_VAL(PIN_RST[g])) u_test_pin_sync (.clk_sys(clk_sys), .srst(srst), .pin(pin_raw[g]),
        .sync_q(pin_s[g]));
    end
  endgenerate

  // Synchronised pins by name.
  assign tck_s = pin_s[0];
  assign tms_s = pin_s[1];
  assign tdi_s = pin_s[2];
  assign trst_s = pin_s[3];

  // Edges of the sampled test clock.
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;
  // Test reset acts at every system edge, whatever tck does, so a stopped tck cannot block it.
  wire tap_rst = srst | ~trst_s;
  wire trace_sel = (ir_q == `IR_INTEST) && (chain_q == `CHAIN_TRACE);
  wire chain_sel = (ir_q == `IR_SCAN_N);

  // Next TAP state from state and TMS.
  function [3:0] tap_next;
    input [3:0] s;
    input m;
    begin
      case (s)
        `ST_RESET: tap_next = m ? `ST_RESET : `ST_IDLE;
        `ST_IDLE: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_DR: tap_next = m ? `ST_SEL_IR : `ST_CAP_DR;
        `ST_CAP_DR: tap_next = m ? `ST_EX1_DR : `ST_SH_DR;
        `ST_SH_DR: tap_next = m ? `ST_EX1_DR : `ST_SH_DR;
        `ST_EX1_DR: tap_next = m ? `ST_UPD_DR : `ST_PAU_DR;
        `ST_PAU_DR: tap_next = m ? `ST_EX2_DR : `ST_PAU_DR;
        `ST_EX2_DR: tap_next = m ? `ST_UPD_DR : `ST_SH_DR;
        `ST_UPD_DR: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_IR: tap_next = m ? `ST_RESET : `ST_CAP_IR;
        `ST_CAP_IR: tap_next = m ? `ST_EX1_IR : `ST_SH_IR;
        `ST_SH_IR: tap_next = m ? `ST_EX1_IR : `ST_SH_IR;
        `ST_EX1_IR: tap_next = m ? `ST_UPD_IR : `ST_PAU_IR;
        `ST_PAU_IR: tap_next = m ? `ST_EX2_IR : `ST_PAU_IR;
        `ST_EX2_IR: tap_next = m ? `ST_UPD_IR : `ST_SH_IR;
        `ST_UPD_IR: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        default: tap_next = `ST_RESET;
      endcase
    end
  endfunction

  // True in either shift state, the only states in which tdo carries data.
  // Used for the enable only; the output value decodes the same two states directly.
  function in_shift;
    input [3:0] s;
    begin
      in_shift = (s == `ST_SH_DR) || (s == `ST_SH_IR);
    end
  endfunction

  // Controller state, instruction and chain select.
  always @(posedge clk_sys) begin
    if (srst) begin
      // Starts at the idle level of the pin, so the first sample after reset shows no edge.
      tck_prev_q <= 1'b1;
    end else begin
      tck_prev_q <= tck_s;
    end
    if (tap_rst) begin
      st_q <= `ST_RESET;
      ir_q <= `IR_BYPASS;
      ir_sh_q <= {`IR_W{1'b0}};
      chain_q <= {`CHAIN_W{1'b0}};
      chain_sh_q <= {`CHAIN_W{1'b0}};
      byp_q <= 1'b0;
    end else if (tck_rise) begin
      st_q <= tap_next(st_q, tms_s);
      case (st_q)
        `ST_RESET: begin
          ir_q <= `IR_BYPASS;
        end
        `ST_CAP_IR: begin
          ir_sh_q <= {{(`IR_W-1){1'b0}}, 1'b1};
        end
        `ST_SH_IR: begin
          ir_sh_q <= {tdi_s, ir_sh_q[`IR_W-1:1]};
        end
        `ST_UPD_IR: begin
          ir_q <= ir_sh_q;
        end
        `ST_CAP_DR: begin
          byp_q <= 1'b0;
          chain_sh_q <= chain_q;
        end
        `ST_SH_DR: begin
          byp_q <= tdi_s;
          if (chain_sel) begin
            chain_sh_q <= {tdi_s, chain_sh_q[`CHAIN_W-1:1]};
          end
        end
        `ST_UPD_DR: begin
          if (chain_sel) begin
            chain_q <= chain_sh_q;
          end
        end
        default: begin
          ir_q <= ir_q;
        end
      endcase
    end
  end

  // Trace chain shift register and register access.
  always @(posedge clk_sys) begin
    if (tap_rst) begin
      scan_q <= {`SCAN_W{1'b0}};
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= {`ADDR_W{1'b0}};
      reg_wdata_q <= {`DATA_W{1'b0}};
      rd_hold_q <= {`DATA_W{1'b0}};
      rd_pend_q <= 1'b0;
    end else begin
      // Strobes are single-cycle pulses; they are raised only by the update branch below.
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      // The register side answers one cycle after the read strobe, so the data is taken then.
      rd_pend_q <= reg_rd_q;
      // Read data is held so capture may come long after the read strobe.
      if (rd_pend_q) begin
        rd_hold_q <= reg_rdata;
      end
      if (tck_rise && trace_sel) begin
        case (st_q)
          `ST_CAP_DR: begin
            scan_q[`DATA_W-1:0] <= rd_hold_q;
          end
          `ST_SH_DR: begin
            scan_q <= {tdi_s, scan_q[`SCAN_W-1:1]};
          end
          `ST_UPD_DR: begin
            reg_addr_q <= scan_q[`FLD_ADDR_LSB +: `ADDR_W];
            if (scan_q[`FLD_DIR_BIT]) begin
              reg_wr_q <= 1'b1;
              reg_wdata_q <= scan_q[`FLD_DATA_LSB +: `DATA_W];
            end else begin
              reg_rd_q <= 1'b1;
            end
          end
          default: begin
            scan_q <= scan_q;
          end
        endcase
      end
    end
  end

  // Serial output value for the current shift state.
  always @* begin
    tdo_d = 1'b0;
    if (st_q == `ST_SH_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (st_q == `ST_SH_DR) begin
      if (trace_sel) begin
        tdo_d = scan_q[0];
      end else if (chain_sel) begin
        tdo_d = chain_sh_q[0];
      end else begin
        tdo_d = byp_q;
      end
    end
  end

  // Output moves on the falling edge so it is stable for the controller's rising-edge sample.
  // The enable follows the same edge, so the pin is released half a test clock after the
  // last shifted bit has been taken by the controller.
  // Limitation: tdo lags the pin edge by the synchroniser, so tck must stay at or below an eighth of clk_sys.
  always @(posedge clk_sys) begin
    if (tap_rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tdo_d;
      tdo_oe_q <= in_shift(st_q);
    end
  end
endmodule // trace_scan_port

// *** verification/jtag_host_model.sv ***
`timescale 1ns/1ps
// Test controller: 800 ns test clock that rests high between frames.
module jtag_host_model (
  input wire clk_sys, // Bench clock.
  input wire tdo_q, // Serial out.
  input wire tdo_oe_q, // Out enable of the serial out.
  output logic tck, // Test clock.
  output logic tms, // Mode select.
  output logic tdi // Serial in.
);
  logic oe_ok; // Serial out was enabled at every bit of the last shift.
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Low phase is five cycles so the output settles before it is taken at the rise.
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (5) @(posedge clk_sys);
    o = tdo_q;
    tck <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // From idle: shift n bits LSB first, update, back to idle.
  task automatic shift(input logic ir, input int n, input logic [39:0] din, output logic [39:0] dout);
    logic o;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    repeat (2) step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
      oe_ok = oe_ok & tdo_oe_q;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule // jtag_host_model

// *** verification/trace_scan_port_chk.sv ***
`timescale 1ns/1ps
`include "trace_scan_map.vh"
// Ties the strobes and the serial output to the test clock edges.
module trace_scan_port_chk (
  input wire clk_sys, // Clock.
  input wire srst, // Reset.
  input wire tck, // Test clock.
  input wire trst_n, // Test reset.
  input wire tdo_q, // Serial out.
  input wire tdo_oe_q, // Out enable.
  input wire reg_wr_q, // Write strobe.
  input wire reg_rd_q, // Read strobe.
  input wire [`ADDR_W-1:0] reg_addr_q, // Address.
  input wire [`DATA_W-1:0] reg_wdata_q // Write data.
);
  // Test reset clears outputs late through its synchroniser, so it masks all checks.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst || !trst_n);
  wire acc = reg_wr_q || reg_rd_q;
  a_access_gap: assert property (acc |=> !acc [*8])
    else $error("two accesses too close");
  a_no_both: assert property (!(reg_wr_q && reg_rd_q))
    else $error("read and write together");
  a_wr_after_rise: assert property ($rose(reg_wr_q) |-> $past(tck, 2))
    else $error("write not after a test clock rise");
  a_rd_after_rise: assert property ($rose(reg_rd_q) |-> $past(tck, 2))
    else $error("read not after a test clock rise");
  a_rd_pulse: assert property (reg_rd_q |=> !reg_rd_q ##1 !reg_rd_q)
    else $error("read strobe too long");
  a_tdo_on_fall: assert property ($changed(tdo_q) && tdo_oe_q |-> !$past(tck, 2))
    else $error("serial out moved after a rise");
  a_addr_hold: assert property ($changed(reg_addr_q) |-> acc)
    else $error("address moved without access");
  a_wdata_hold: assert property ($changed(reg_wdata_q) |-> reg_wr_q)
    else $error("write data moved without write");
  cover property (reg_wr_q);
  cover property (reg_rd_q);
  cover property ($rose(tdo_oe_q));
endmodule // trace_scan_port_chk

// *** verification/trace_scan_port_tb_top.sv ***
`timescale 1ns/1ps
module trace_scan_port_tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic trst_n = 1'b1;
  logic [31:0] reg_rdata = 32'h0;
  wire tck, tms, tdi, tdo_q, tdo_oe_q, reg_wr_q, reg_rd_q;
  wire [6:0] reg_addr_q;
  wire [31:0] reg_wdata_q;
  int error_cnt = 0, total_checks = 0, wr_n = 0, rd_n = 0;
  logic [6:0] seen_a;
  logic [31:0] seen_d;
  logic [39:0] o;
  always #50 clk_sys = ~clk_sys;
  trace_scan_port u_trace_scan_port (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q),
    .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q), .reg_rdata(reg_rdata));
  jtag_host_model u_jtag_host_model (.clk_sys(clk_sys), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .tck(tck), .tms(tms),
    .tdi(tdi));
  // Counts strobes and plays the registers; a read answers one cycle later.
  always @(posedge clk_sys) begin
    if (reg_wr_q === 1'b1) wr_n <= wr_n + 1;
    if (reg_wr_q === 1'b1) seen_d <= reg_wdata_q;
    if (reg_rd_q === 1'b1) rd_n <= rd_n + 1;
    if (reg_rd_q === 1'b1) reg_rdata <= 32'h5a00_0000 | reg_addr_q;
    if (reg_wr_q || reg_rd_q) seen_a <= reg_addr_q;
  end
  task automatic check(input string what, input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The wait covers the strobe, which trails the update by a few cycles.
  task automatic scan(input logic [39:0] w);
    u_jtag_host_model.shift(1'b0, 40, w, o);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic sel(input logic [3:0] ch);
    u_jtag_host_model.shift(1'b1, 4, 40'h2, o);
    u_jtag_host_model.shift(1'b0, 4, {36'h0, ch}, o);
    u_jtag_host_model.shift(1'b1, 4, 40'hc, o);
  endtask
  task automatic t_write;
    int w0;
    sel(4'h6);
    w0 = wr_n;
    scan({1'b1, 7'h55, 32'ha5a5_0f0f});
    check("writes", 40'(wr_n - w0), 40'h1);
    check("wr addr", {33'h0, seen_a}, 40'h55);
    check("wr data", {8'h0, seen_d}, 40'ha5a5_0f0f);
    check("oe in shift", {39'h0, u_jtag_host_model.oe_ok}, 40'h1);
    check("oe idle", {39'h0, tdo_oe_q}, 40'h0);
    $display("test write done");
  endtask
  // A read ignores the data field; the value comes out on the next scan.
  task automatic t_read;
    int r0;
    r0 = rd_n;
    scan({1'b0, 7'h2a, 32'hffff_ffff});
    check("reads", 40'(rd_n - r0), 40'h1);
    check("rd addr", {33'h0, seen_a}, 40'h2a);
    check("wdata kept", {8'h0, reg_wdata_q}, 40'ha5a5_0f0f);
    u_jtag_host_model.shift(1'b0, 40, {1'b0, 7'h11, 32'h0}, o);
    check("rd value", {8'h0, o[31:0]}, 40'h5a00_002a);
    $display("test read done");
  endtask
  // Test reset with the clock parked drops the chain; another chain is refused too.
  task automatic t_refuse;
    int n0;
    trst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("addr reset", {33'h0, reg_addr_q}, 40'h0);
    u_jtag_host_model.step(1'b0, 1'b0, o[0]);
    u_jtag_host_model.shift(1'b1, 4, 40'hc, o);
    n0 = wr_n + rd_n;
    scan({1'b1, 7'h55, 32'h0});
    check("after trst", 40'(wr_n + rd_n - n0), 40'h0);
    sel(4'h3);
    scan({1'b1, 7'h55, 32'h0});
    check("off chain", 40'(wr_n + rd_n - n0), 40'h0);
    $display("test refuse done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    u_jtag_host_model.step(1'b0, 1'b0, o[0]);
    t_write;
    t_read;
    t_refuse;
    results;
  end
  // Watchdog far above the dozen scans of the run.
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    results;
  end
endmodule // trace_scan_port_tb_top
bind trace_scan_port trace_scan_port_chk u_chk (.*);
